/* File: rtl/adc_seq_defines.svh */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Serial frame shape, counted in falling link clock edges
`define XFER_CLOCKS      5'h10
`define CMD_BITS         5'h0c
`define ADDR_DONE_FALL   5'h04
`define MUX_FALL         5'h0e
`define FALL_CNT_W       5

// Pin levels at rest, {sclk, cs_n, din}
`define LINK_IDLE_LVL    3'h6

// Result word layout on the serial output
`define RES_BITS         12
`define LEAD_ZEROS       2'h0
`define RES_PAD          4'h0

// Power mode encodings
`define PM_NORMAL        2'h3
`define PM_FULL_DOWN     2'h2
`define PM_AUTO_DOWN     2'h1
`define PM_INVALID       2'h0

// Configuration after reset: normal power, channel 0, no sequence
`define CFG_RESET        12'h030

// Result buffer
`define FIFO_DEPTH       8
`define CHAN_COUNT       4

`endif

/* File: rtl/adc_seq_pkg.sv */
package adc_seq_pkg;

	// Command word as shifted in, first bit at the top
	typedef struct packed {
		logic       write_qualify;
		logic       sequencer_mode_high;
		logic [1:0] ignored_bit_hi;
		logic       channel_select_high;
		logic       channel_select_low;
		logic       power_select_high;
		logic       power_select_low;
		logic       sequencer_mode_low;
		logic       ignored_bit_lo;
		logic       range_sel;
		logic       coding_sel;
	} cmd_word_t;

	// Request handed to the converter core at each conversion start
	typedef struct packed {
		logic [1:0] channel;
		logic       range_sel;
		logic       coding_sel;
	} conv_req_t;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_XFER = 2'b01,
		LINK_TAIL = 2'b10
	} link_state_t;

endpackage

/* File: rtl/link_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
	parameter int               WIDTH   = 3,
	// Idle pin levels, so leaving reset shows no false edge
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* File: rtl/sample_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_q[rd_q];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

`default_nettype wire

/* File: rtl/adc_channel_sequencer_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"

module adc_channel_sequencer_control #(
	parameter int RES_W = `RES_BITS,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// Serial link pins
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  din,
	output logic                       dout,
	output logic                       dout_oe_n,
	// Conversion request to the converter core
	output logic                       conv_start,
	output adc_seq_pkg::conv_req_t     conv_req,
	// Results from the converter core
	input  wire logic                  res_valid,
	input  wire logic [RES_W-1:0]      res_data,
	output logic                       res_ready,
	// Analog front end control
	output logic [1:0]                 mux_sel,
	output logic [`CHAN_COUNT-1:0]     analog_input_en,
	output logic                       powered,
	// Frame cut short by chip select
	output logic                       frame_abort
);

	logic                      sclk_s;
	logic                      cs_n_s;
	logic                      din_s;
	logic                      sclk_p_q;
	logic                      cs_n_p_q;
	logic                      cs_fall;
	logic                      cs_rise;
	logic                      fall_now;
	logic [`FALL_CNT_W-1:0]    fall_cnt_q;
	logic [`FALL_CNT_W-1:0]    nfall;
	adc_seq_pkg::link_state_t  state_q;
	adc_seq_pkg::link_state_t  state_d;
	logic [`CMD_BITS-1:0]      cmd_sh_q;
	adc_seq_pkg::cmd_word_t    cmd;
	adc_seq_pkg::cmd_word_t    cfg_q;
	logic                      commit;
	logic                      wrote_q;
	logic [1:0]                cur_ch_q;
	logic [1:0]                last_ch_q;
	logic                      seq_run_q;
	logic [1:0]                next_ch;
	logic [1:0]                next_last;
	logic                      next_run;
	logic [1:0]                step_ch;
	logic [15:0]               out_sh_q;
	logic                      drive_n_q;
	logic                      powered_q;
	logic                      start_q;
	adc_seq_pkg::conv_req_t    req_q;
	logic                      abort_q;
	logic                      pop;
	logic                      fifo_valid;
	logic [RES_W-1:0]          fifo_data;

	// Pins come from the host's domain
	link_sync #(
		.WIDTH   (3),
		.RST_VAL (`LINK_IDLE_LVL)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({sclk, cs_n, din}),
		.sync_out ({sclk_s, cs_n_s, din_s})
	);

	// Core may finish a result ahead of the drain point
	sample_fifo #(
		.WIDTH (RES_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (res_valid),
		.in_data   (res_data),
		.in_ready  (res_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (pop)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_p_q <= 1'b1;
			cs_n_p_q <= 1'b1;
		end else begin
			sclk_p_q <= sclk_s;
			cs_n_p_q <= cs_n_s;
		end
	end

	assign cs_fall  = cs_n_p_q & ~cs_n_s;
	assign cs_rise  = ~cs_n_p_q & cs_n_s;
	assign fall_now = (state_q == adc_seq_pkg::LINK_XFER)
		& sclk_p_q & ~sclk_s & ~cs_n_s;
	assign nfall    = fall_cnt_q + 1'b1;
	assign commit   = fall_now && (nfall == `MUX_FALL);
	assign pop      = fall_now && (nfall == `ADDR_DONE_FALL);
	assign cmd      = adc_seq_pkg::cmd_word_t'(cmd_sh_q);

	// Frame sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_seq_pkg::LINK_IDLE: begin
				if (cs_fall) begin
					state_d = adc_seq_pkg::LINK_XFER;
				end
			end
			adc_seq_pkg::LINK_XFER: begin
				if (cs_rise) begin
					state_d = adc_seq_pkg::LINK_IDLE;
				end else if (fall_now && nfall == `XFER_CLOCKS) begin
					state_d = adc_seq_pkg::LINK_TAIL;
				end
			end
			adc_seq_pkg::LINK_TAIL: begin
				if (cs_rise) begin
					state_d = adc_seq_pkg::LINK_IDLE;
				end
			end
			default: begin
				state_d = adc_seq_pkg::LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= adc_seq_pkg::LINK_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fall_cnt_q <= '0;
		end else if (cs_fall) begin
			fall_cnt_q <= '0;
		end else if (fall_now) begin
			fall_cnt_q <= nfall;
		end
	end

	// Only the first twelve falls feed the command, top bit first
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmd_sh_q <= '0;
		end else if (fall_now && nfall <= `CMD_BITS) begin
			cmd_sh_q <= {cmd_sh_q[`CMD_BITS-2:0], din_s};
		end
	end

	// Frames cut before fall 14 never reach the commit point, though from fall 4 on they pop a result
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= cs_rise
				&& (state_q == adc_seq_pkg::LINK_XFER);
		end
	end

	// Configuration register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q   <= adc_seq_pkg::cmd_word_t'(`CFG_RESET);
			wrote_q <= 1'b0;
		end else begin
			if (cs_fall) begin
				wrote_q <= 1'b0;
			end
			if (commit && cmd.write_qualify) begin
				cfg_q                <= cmd;
				cfg_q.write_qualify  <= 1'b0;
				cfg_q.ignored_bit_hi <= 2'h0;
				cfg_q.ignored_bit_lo <= 1'b0;
				wrote_q              <= 1'b1;
			end
		end
	end

	// Next step of a running sequence, wrapping after the final one
	assign step_ch = (cur_ch_q == last_ch_q) ? 2'h0
		: cur_ch_q + 2'h1;

	always_comb begin
		next_ch   = cur_ch_q;
		next_last = last_ch_q;
		next_run  = seq_run_q;
		if (cmd.write_qualify) begin
			if (!cmd.sequencer_mode_high) begin
				next_run = 1'b0;
				next_ch  = {cmd.channel_select_high,
					cmd.channel_select_low};
			end else if (cmd.sequencer_mode_low) begin
				next_run  = 1'b1;
				next_ch   = 2'h0;
				next_last = {cmd.channel_select_high,
					cmd.channel_select_low};
			end else if (seq_run_q) begin
				next_ch = step_ch;
			end else begin
				next_ch = {cmd.channel_select_high,
					cmd.channel_select_low};
			end
		end else if (seq_run_q) begin
			next_ch = step_ch;
		end else begin
			// Nothing written: keep the prior written channel
			next_ch = {cfg_q.channel_select_high,
				cfg_q.channel_select_low};
		end
	end

	// Mux moves while the current result is still shifting out
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_ch_q  <= 2'h0;
			last_ch_q <= 2'h0;
			seq_run_q <= 1'b0;
		end else if (commit) begin
			cur_ch_q  <= next_ch;
			last_ch_q <= next_last;
			seq_run_q <= next_run;
		end
	end

	// Conversion start snapshots the settings for this conversion
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
			req_q   <= '0;
		end else begin
			start_q <= cs_fall;
			if (cs_fall) begin
				req_q.channel    <= cur_ch_q;
				req_q.range_sel  <= cfg_q.range_sel;
				req_q.coding_sel <= cfg_q.coding_sel;
			end
		end
	end

	// Serial output word
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_sh_q <= '0;
		end else if (cs_fall) begin
			out_sh_q <= {`LEAD_ZEROS, cur_ch_q, `RES_PAD,
				8'h00};
		end else if (pop) begin
			// Empty buffer sends zeros rather than stale data
			out_sh_q <= {(fifo_valid ? fifo_data
				: {RES_W{1'b0}}), `RES_PAD};
		end else if (fall_now) begin
			out_sh_q <= {out_sh_q[14:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			drive_n_q <= 1'b1;
		end else if (cs_fall) begin
			drive_n_q <= 1'b0;
		end else if (cs_rise) begin
			drive_n_q <= 1'b1;
		end
	end

	// Power management
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			powered_q <= 1'b1;
		end else begin
			case ({cfg_q.power_select_high, cfg_q.power_select_low})
				`PM_NORMAL: begin
					powered_q <= 1'b1;
				end
				`PM_FULL_DOWN: begin
					powered_q <= 1'b0;
				end
				`PM_AUTO_DOWN: begin
					if (cs_fall) begin
						powered_q <= 1'b1;
					end else if (wrote_q && fall_now
						&& nfall == `XFER_CLOCKS) begin
						powered_q <= 1'b0;
					end
				end
				default: begin
					// Invalid code: hold whatever state was reached
					powered_q <= powered_q;
				end
			endcase
		end
	end

	// One enable per analog input
	for (genvar gi = 0; gi < `CHAN_COUNT; gi++) begin : g_en
		assign analog_input_en[gi] = powered_q
			&& (cur_ch_q == 2'(gi));
	end

	assign dout        = out_sh_q[15];
	assign dout_oe_n   = drive_n_q;
	assign conv_start  = start_q;
	assign conv_req    = req_q;
	assign mux_sel     = cur_ch_q;
	assign powered     = powered_q;
	assign frame_abort = abort_q;

endmodule

`default_nettype wire

/* File: dv/host_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
	// Bench clock
	input  wire logic        ref_clk,
	// Link pins
	output logic             sclk,
	output logic             cs_n,
	output logic             din,
	input  wire logic        dout,
	// Captured result word
	output logic             done,
	output logic [15:0]      word
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		done = 1'b0;
		word = 16'h0000;
	end

	// Half period of 16 cycles makes a 160 ns link clock
	task automatic frame(input logic [11:0] cmd, input int falls);
		logic [15:0] w;
		w = 16'h0000;
		@(negedge ref_clk);
		cs_n <= 1'b0;
		for (int k = 0; k < falls; k++) begin
			din <= (k < 12) ? cmd[11-k] : ~din;
			repeat (16) @(negedge ref_clk);
			w = {w[14:0], dout};
			sclk <= 1'b0;
			repeat (16) @(negedge ref_clk);
			sclk <= 1'b1;
		end
		cs_n <= 1'b1;
		din <= ~din;
		if (falls == 16) begin
			word <= w;
			done <= 1'b1;
			@(negedge ref_clk);
			done <= 1'b0;
		end
		// Gap above 1 us so a woken converter is ready
		repeat (210) @(negedge ref_clk);
	endtask
endmodule

`default_nettype wire

/* File: dv/adc_seq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_seq_checker #(
	parameter int RES_W = 12,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic                   ref_clk,
	input wire logic                   rst,
	// Link pins
	input wire logic                   sclk,
	input wire logic                   cs_n,
	input wire logic                   din,
	input wire logic                   dout,
	input wire logic                   dout_oe_n,
	// Converter side
	input wire logic                   conv_start,
	input wire adc_seq_pkg::conv_req_t conv_req,
	input wire logic                   res_valid,
	input wire logic [RES_W-1:0]       res_data,
	input wire logic                   res_ready,
	input wire logic [1:0]             mux_sel,
	input wire logic [3:0]             analog_input_en,
	input wire logic                   powered,
	input wire logic                   frame_abort
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_START_ONE: assert property (
		conv_start |=> !conv_start)
		else $error("conv_start wider than one cycle");
	AST_START_CS: assert property (
		conv_start |-> !cs_n && !$past(cs_n, 3))
		else $error("conv_start outside a frame");
	AST_REQ_HOLD: assert property (
		$changed(conv_req) |-> conv_start)
		else $error("conv_req moved without a start");
	AST_EN_MAP: assert property (
		analog_input_en == (powered ? 4'h1 << mux_sel : 4'h0))
		else $error("input enable does not match channel");
	AST_MUX_FRAME: assert property (
		$changed(mux_sel) |-> !cs_n)
		else $error("channel moved outside a frame");
	AST_PWR_FRAME: assert property (
		$changed(powered) |-> !cs_n)
		else $error("power changed outside a frame");
	AST_OE_IDLE: assert property (
		cs_n [*5] |-> dout_oe_n)
		else $error("dout driven while deselected");
	AST_OE_FRAME: assert property (
		!cs_n [*6] |-> !dout_oe_n)
		else $error("dout released inside a frame");
	AST_ABORT: assert property (
		frame_abort |-> cs_n ##1 !frame_abort)
		else $error("bad abort pulse");
	AST_DOUT_LEAD: assert property (
		$fell(dout_oe_n) |-> !dout)
		else $error("first output bit is not a lead zero");

	COV_START: cover property (conv_start);
	COV_ABORT: cover property (frame_abort);
	COV_DOWN: cover property ($fell(powered));
	COV_FULL: cover property (res_valid && !res_ready);
endmodule

bind adc_channel_sequencer_control adc_seq_checker #(
	.RES_W (RES_W),
	.DEPTH (DEPTH)
) chk (
	.ref_clk         (ref_clk),
	.rst             (rst),
	.sclk            (sclk),
	.cs_n            (cs_n),
	.din             (din),
	.dout            (dout),
	.dout_oe_n       (dout_oe_n),
	.conv_start      (conv_start),
	.conv_req        (conv_req),
	.res_valid       (res_valid),
	.res_data        (res_data),
	.res_ready       (res_ready),
	.mux_sel         (mux_sel),
	.analog_input_en (analog_input_en),
	.powered         (powered),
	.frame_abort     (frame_abort)
);

`default_nettype wire

/* File: dv/adc_channel_sequencer_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_channel_sequencer_control_bench;
	logic                   ref_clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   res_valid = 1'b0;
	logic [11:0]            res_data = 12'h000;
	logic                   sclk, cs_n, din, dout, dout_oe_n, done;
	logic                   conv_start, res_ready, powered, frame_abort;
	adc_seq_pkg::conv_req_t conv_req;
	logic [1:0]             mux_sel, ch, fin, pm;
	logic [3:0]             analog_input_en;
	logic [15:0]            word;
	logic                   run, rng, cod;
	logic [31:0]            rnd = 32'h00012138;
	int                     err_count = 0;
	int                     checks = 0;
	int                     n_abort = 0;
	int                     ab_exp = 0;
	logic [15:0]            wq[$];
	logic [3:0]             rq[$];
	logic [11:0]            dq[$];

	always #2.5 ref_clk = ~ref_clk;

	adc_channel_sequencer_control dut (
		.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout), .dout_oe_n(dout_oe_n),
		.conv_start(conv_start), .conv_req(conv_req),
		.res_valid(res_valid), .res_data(res_data),
		.res_ready(res_ready), .mux_sel(mux_sel),
		.analog_input_en(analog_input_en), .powered(powered),
		.frame_abort(frame_abort)
	);

	host_link_model host (
		.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .done(done), .word(word)
	);

	task automatic note(input logic bad, input logic [15:0] g, e);
		checks++;
		if (bad) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_word(input logic [15:0] g, e);
		note(g !== e, g, e);
	endtask

	task automatic cmp_req(input logic [3:0] g, e);
		note(g !== e, {12'h000, g}, {12'h000, e});
	endtask

	task automatic cmp_flag(input logic g, e);
		note(g !== e, {15'h0000, g}, {15'h0000, e});
	endtask

	task automatic stop_test;
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Outputs are read away from the edge that launches them
	always @(negedge ref_clk) begin
		if (done)
			cmp_word(word, wq.pop_front());
		if (conv_start === 1'b1)
			cmp_req(conv_req, rq.pop_front());
		if (frame_abort === 1'b1)
			n_abort++;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			rnd = xs(rnd);
			@(negedge ref_clk);
			res_valid <= 1'b1;
			res_data <= rnd[11:0];
			if (res_ready === 1'b1)
				dq.push_back(rnd[11:0]);
			@(negedge ref_clk);
			res_valid <= 1'b0;
		end
	endtask

	task automatic xfer(input logic [11:0] c, input int f = 16);
		logic [11:0] d;
		d = 12'h000;
		rq.push_back({ch, rng, cod});
		if (dq.size() > 0)
			d = dq.pop_front();
		if (f == 16)
			wq.push_back({2'b00, ch, d});
		host.frame(c, f);
		ab_exp += (f < 16);
		cmp_flag(n_abort == ab_exp, 1'b1);
		cmp_flag(dout_oe_n, 1'b1);
		if (f < 16)
			return;
		if (c[11]) begin
			rng = c[1];
			cod = c[0];
			pm = c[5:4];
		end
		if (c[11] && c[10] && c[3]) begin
			run = 1'b1;
			fin = c[7:6];
			ch = 2'd0;
		end else if (c[11] && !(c[10] && run)) begin
			run = 1'b0;
			ch = c[7:6];
		end else if (run)
			ch = (ch == fin) ? 2'd0 : ch + 2'd1;
		cmp_flag(powered, pm == 2'b11 || (pm == 2'b01 && !c[11]));
		cmp_flag(mux_sel === ch, 1'b1);
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk);
		err_count++;
		stop_test();
	end

	initial begin
		{ch, fin, run, rng, cod} = 7'h00;
		pm = 2'b11;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		xfer(12'h040);
		for (int i = 0; i < 4; i++) begin
			push(1);
			xfer({4'hb, i[1:0], 4'hf, rnd[1:0]});
		end
		xfer(12'h8b0, 8);
		xfer(12'h000);
		xfer(12'hcb8);
		repeat (4) xfer(12'h000);
		xfer(12'hcb2);
		repeat (2) xfer(12'h000);
		xfer(12'h870);
		xfer(12'h000);
		xfer(12'h860);
		xfer(12'h000);
		xfer(12'h870);
		xfer(12'h850);
		xfer(12'h000);
		xfer(12'h870);
		push(9);
		cmp_flag(res_ready, 1'b0);
		repeat (9) xfer(12'h000);
		cmp_flag(res_ready, 1'b1);
		cmp_flag(rq.size() == 0 && wq.size() == 0, 1'b1);
		stop_test();
	end
endmodule

`default_nettype wire
